/* core/bcr_consts.svh */
// Constants for the bridge configuration header register bank
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH

// Byte addresses on the register bus
`define BCR_OFS_STATUS 8'h04
`define BCR_OFS_CLASS 8'h08
`define BCR_OFS_CACHE 8'h0c
`define BCR_OFS_BUSNUM 8'h18
`define BCR_OFS_CTRL 8'h40

// Status field positions
`define BCR_BIT_CAPLIST 20
`define BCR_BIT_66MHZ 21
`define BCR_BIT_FB2B 23
`define BCR_BIT_MDPERR 24
`define BCR_BIT_DEVSEL_LO 25
`define BCR_BIT_STABORT 27
`define BCR_BIT_RTABORT 28
`define BCR_BIT_RMABORT 29
`define BCR_BIT_SSERR 30
`define BCR_BIT_DPERR 31

// Control field positions
`define BCR_BIT_PERR_RESP 6
`define BCR_BIT_SERR_EN 8

// Fixed read values and the largest legal cache line size
`define BCR_DEVSEL_MEDIUM 2'h1
`define BCR_BASE_CLASS 8'h06
`define BCR_SUB_CLASS 8'h04
`define BCR_PROG_IF 8'h00
`define BCR_HDR_TYPE 8'h01
`define BCR_CACHE_MAX 8'h10

// Reset values
`define BCR_RST_BYTE 8'h00
`define BCR_RST_FLAGS 6'h00

`endif

/* core/bcr_pkg.sv */
// Types shared by the bridge configuration header register bank
package bcr_pkg;

	// Events reported by the forwarding logic, each a one-cycle pulse
	typedef struct packed {
		logic mst_data_perr;   // Bridge as primary master saw a data parity error
		logic tgt_abort_sent;  // Bridge as target ended a cycle with target abort
		logic tgt_abort_rcvd;  // Bridge as master got a target abort
		logic mst_abort;       // Bridge as master got no response
		logic addr_perr;       // Address parity error seen on the primary
		logic data_perr;       // Data parity error seen on the primary
		logic serr_req;        // Forwarding logic wants the system error line
	} bcr_evt_t;

	// Sticky status flags, bits 31 down to 27, then bit 24
	typedef struct packed {
		logic dperr;
		logic sserr;
		logic rmabort;
		logic rtabort;
		logic stabort;
		logic mdperr;
	} bcr_flags_t;

endpackage

/* core/bcr_regs.sv */
// Primary-side configuration header registers of a two-port bridge, APB slave
`include "bcr_consts.svh"

module bcr_regs import bcr_pkg::*; #(
	parameter logic [7:0] REVISION = 8'h5a // Arbitrary value
) (
	input wire logic SYS_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire bcr_evt_t EVENTS_I,
	input wire logic FRAME_START_I,
	input wire logic XFER_ACTIVE_I,
	input wire logic [7:0] XFER_DWORD_I,
	output logic LINE_END_O,
	output logic [7:0] LINE_DWORDS_O,
	output logic LAT_EXPIRED_O,
	output logic [7:0] UPSTREAM_BUS_O,
	output logic [7:0] DOWNSTREAM_BUS_O,
	output logic PRI_SERR_OUT_O,
	output logic PRI_SERR_OUT_OE_N_O
);

	bcr_flags_t flags_r;
	bcr_flags_t flags_nxt;
	bcr_flags_t flags_set;
	bcr_flags_t flags_clr;
	logic [7:0] cache_r;
	logic [7:0] lat_r;
	logic [7:0] upbus_r;
	logic [7:0] downbus_r;
	logic perr_resp_r;
	logic serr_en_r;
	logic [7:0] lat_cnt_r;
	logic [7:0] lat_cnt_nxt;
	logic lat_exp_nxt;
	logic [31:0] prdata_r;
	logic [31:0] rdata;
	logic pready_r;
	logic pslverr_r;
	logic serr_r;
	logic serr_nxt;
	logic line_end_r;
	logic line_end_nxt;
	logic [7:0] line_dw_r;
	logic [7:0] line_dw_nxt;
	logic [7:0] cache_nxt;
	logic [7:0] lat_nxt;
	logic [7:0] upbus_nxt;
	logic [7:0] downbus_nxt;
	logic perr_resp_nxt;
	logic serr_en_nxt;
	logic pready_nxt;
	logic pslverr_nxt;
	logic [31:0] prdata_nxt;
	logic lat_exp_r;
	logic serr_data_r;

	// Register map, one aligned 32-bit word each:
	//   0x04 status: bits 31:27 and 24 sticky, write one to clear;
	//        bits 26:25, 23, 21 and 20 fixed; every other bit reads zero
	//   0x08 class code in bits 31:8, revision in bits 7:0, all read-only
	//   0x0c cache line size 7:0, latency timer 15:8, header type 23:16,
	//        top byte reads zero
	//   0x18 upstream bus number 7:0, downstream bus number 15:8
	//   0x40 response enables: bit 6 parity response, bit 8 system error
	// Any other address answers with an error and reads zero.
	// Accesses never wait: ready rises in the first access cycle, so the
	// master may place a new setup cycle right after it.
	// A hardware event and a software clear in one cycle keep the flag set,
	// so an error cannot slip past a clear that races with it.
	// Invalid cache sizes are stored as written but treated as no line;
	// software is trusted to program only legal sizes.

	// Bus phase decode
	wire logic setup_ph = PSEL_I & ~PENABLE_I;
	wire logic commit = PSEL_I & PENABLE_I & pready_r;
	wire logic wr_commit = commit & PWRITE_I;
	wire logic hit_status = (PADDR_I == `BCR_OFS_STATUS);
	wire logic hit_class = (PADDR_I == `BCR_OFS_CLASS);
	wire logic hit_cache = (PADDR_I == `BCR_OFS_CACHE);
	wire logic hit_busnum = (PADDR_I == `BCR_OFS_BUSNUM);
	wire logic hit_ctrl = (PADDR_I == `BCR_OFS_CTRL);
	wire logic mapped = hit_status | hit_class | hit_cache | hit_busnum | hit_ctrl;

	// Byte-lane write enables per register
	wire logic [3:0] wr_status = {4{wr_commit & hit_status}} & PSTRB_I;
	wire logic [3:0] wr_cache = {4{wr_commit & hit_cache}} & PSTRB_I;
	wire logic [3:0] wr_busnum = {4{wr_commit & hit_busnum}} & PSTRB_I;
	wire logic [3:0] wr_ctrl = {4{wr_commit & hit_ctrl}} & PSTRB_I;

	// Status word; hardwired bits and the sticky flags
	wire logic [15:0] status_hi = {
		flags_r.dperr,
		flags_r.sserr,
		flags_r.rmabort,
		flags_r.rtabort,
		flags_r.stabort,
		`BCR_DEVSEL_MEDIUM,
		flags_r.mdperr,
		1'b1,
		1'b0,
		1'b1,
		1'b1,
		4'h0
	};

	// Command low half is outside this bank, so the status word reads zero there
	wire logic [31:0] status_word = {status_hi, 16'h0000};
	wire logic [31:0] class_word = {`BCR_BASE_CLASS, `BCR_SUB_CLASS, `BCR_PROG_IF, REVISION};
	wire logic [31:0] cache_word = {8'h00, `BCR_HDR_TYPE, lat_r, cache_r};
	wire logic [31:0] busnum_word = {16'h0000, downbus_r, upbus_r};
	wire logic [31:0] ctrl_word = {23'h000000, serr_en_r, 1'b0, perr_resp_r, 6'h00};

	// Read data selection
	assign rdata = ({32{hit_status}} & status_word)
		| ({32{hit_class}} & class_word)
		| ({32{hit_cache}} & cache_word)
		| ({32{hit_busnum}} & busnum_word)
		| ({32{hit_ctrl}} & ctrl_word);

	// Address parity error escalates to system error only with parity response on
	wire logic serr_want = EVENTS_I.serr_req | (perr_resp_r & EVENTS_I.addr_perr);

	// Hardware set terms; they win over a clear in the same cycle
	assign flags_set.dperr = EVENTS_I.addr_perr | EVENTS_I.data_perr;
	assign flags_set.sserr = serr_nxt;
	assign flags_set.rmabort = EVENTS_I.mst_abort;
	assign flags_set.rtabort = EVENTS_I.tgt_abort_rcvd;
	assign flags_set.stabort = EVENTS_I.tgt_abort_sent;
	assign flags_set.mdperr = EVENTS_I.mst_data_perr & perr_resp_r;

	// Write-one-to-clear from status bits 31:27 and bit 24
	assign flags_clr = {PWDATA_I[31:27] & {5{wr_status[3]}}, PWDATA_I[24] & wr_status[3]};
	assign flags_nxt = (flags_r & ~flags_clr) | flags_set;

	// The line is driven only while enabled; otherwise released
	assign serr_nxt = serr_want & serr_en_r;

	// Only power-of-two sizes up to the maximum steer bursts; others act as no line
	wire logic cache_ok = (cache_r != 8'h00) && ((cache_r & (cache_r - 8'h01)) == 8'h00)
		&& (cache_r <= `BCR_CACHE_MAX);
	assign line_dw_nxt = cache_ok ? cache_r : 8'h00;
	// Last dword of a line: low address bits all ones within the line size
	assign line_end_nxt = cache_ok & XFER_ACTIVE_I
		& (((XFER_DWORD_I + 8'h01) & (cache_r - 8'h01)) == 8'h00);

	// Latency counter reloads on each frame start and runs down to zero
	assign lat_cnt_nxt = FRAME_START_I ? lat_r : ((lat_cnt_r != 8'h00) ? lat_cnt_r - 8'h01 : 8'h00);
	assign lat_exp_nxt = XFER_ACTIVE_I & ~FRAME_START_I & (lat_cnt_r == 8'h00);

	// Bus answer: one wait-free access phase after each setup cycle
	assign pready_nxt = setup_ph;
	assign pslverr_nxt = setup_ph & ~mapped;
	// Read data is captured at setup so it stands through the access phase and after
	assign prdata_nxt = (setup_ph & ~PWRITE_I) ? rdata : prdata_r;

	// Software-written fields, each updated only through its own byte lane
	assign cache_nxt = wr_cache[0] ? PWDATA_I[7:0] : cache_r;
	assign lat_nxt = wr_cache[1] ? PWDATA_I[15:8] : lat_r;
	assign upbus_nxt = wr_busnum[0] ? PWDATA_I[7:0] : upbus_r;
	assign downbus_nxt = wr_busnum[1] ? PWDATA_I[15:8] : downbus_r;
	// Enables live in an extra word, as the command half is outside this bank
	assign perr_resp_nxt = wr_ctrl[0] ? PWDATA_I[`BCR_BIT_PERR_RESP] : perr_resp_r;
	assign serr_en_nxt = wr_ctrl[1] ? PWDATA_I[`BCR_BIT_SERR_EN] : serr_en_r;

	// Ready flop
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= pready_nxt;
		end
	end

	// Error answer flop, high only beside ready
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			pslverr_r <= 1'b0;
		end else begin
			pslverr_r <= pslverr_nxt;
		end
	end

	// Read data holding register
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			prdata_r <= 32'h00000000;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	// One sticky flag per status bit; reset clears them all
	for (genvar g = 0; g < $bits(bcr_flags_t); g++) begin : gen_flag
		always_ff @(posedge SYS_CLK_I) begin
			if (SYS_RST_I) begin
				flags_r[g] <= 1'b0;
			end else begin
				flags_r[g] <= flags_nxt[g];
			end
		end
	end

	// Cache line size
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			cache_r <= `BCR_RST_BYTE;
		end else begin
			cache_r <= cache_nxt;
		end
	end

	// Latency timer value
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			lat_r <= `BCR_RST_BYTE;
		end else begin
			lat_r <= lat_nxt;
		end
	end

	// Upstream bus number
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			upbus_r <= `BCR_RST_BYTE;
		end else begin
			upbus_r <= upbus_nxt;
		end
	end

	// Downstream bus number
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			downbus_r <= `BCR_RST_BYTE;
		end else begin
			downbus_r <= downbus_nxt;
		end
	end

	// Parity response enable
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			perr_resp_r <= 1'b0;
		end else begin
			perr_resp_r <= perr_resp_nxt;
		end
	end

	// System error driver enable
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			serr_en_r <= 1'b0;
		end else begin
			serr_en_r <= serr_en_nxt;
		end
	end

	// Latency down-counter
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			lat_cnt_r <= 8'h00;
		end else begin
			lat_cnt_r <= lat_cnt_nxt;
		end
	end

	// Line end strobe, one cycle late so the output comes from a flop
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			line_end_r <= 1'b0;
		end else begin
			line_end_r <= line_end_nxt;
		end
	end

	// Valid line size seen by the burst logic
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			line_dw_r <= 8'h00;
		end else begin
			line_dw_r <= line_dw_nxt;
		end
	end

	// System error drive, the same cycle its status flag sets
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			serr_r <= 1'b0;
		end else begin
			serr_r <= serr_nxt;
		end
	end

	// Expiry flag
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			lat_exp_r <= 1'b0;
		end else begin
			lat_exp_r <= lat_exp_nxt;
		end
	end

	// Open-drain data level; only the enable ever moves
	always_ff @(posedge SYS_CLK_I) begin
		if (SYS_RST_I) begin
			serr_data_r <= 1'b0;
		end else begin
			serr_data_r <= 1'b0;
		end
	end

	// Bus outputs
	assign PRDATA_O = prdata_r;
	assign PREADY_O = pready_r;
	assign PSLVERR_O = pslverr_r;
	// Burst helper outputs
	assign LINE_END_O = line_end_r;
	assign LINE_DWORDS_O = line_dw_r;
	assign LAT_EXPIRED_O = lat_exp_r;
	// Bus numbers for the forwarding decode
	assign UPSTREAM_BUS_O = upbus_r;
	assign DOWNSTREAM_BUS_O = downbus_r;
	// Open-drain line drives low while the active-low enable is low
	assign PRI_SERR_OUT_O = serr_data_r;
	assign PRI_SERR_OUT_OE_N_O = ~serr_r;

endmodule // bcr_regs

/* verif/bcr_cfg_master.sv */
// Configuration master model that issues APB cycles to the register bank
module bcr_cfg_master (
	input wire logic clk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus from time zero
	initial {psel, penable, pwrite, paddr, pwdata} = '0;

	// Setup, then access held until pready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
endmodule // bcr_cfg_master

/* verif/bcr_regs_assertions.sv */
// Port-level checks for the configuration register bank
`include "bcr_consts.svh"
module bcr_regs_chk import bcr_pkg::*; (
	input wire logic SYS_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire bcr_evt_t EVENTS_I,
	input wire logic FRAME_START_I,
	input wire logic XFER_ACTIVE_I,
	input wire logic LINE_END_O,
	input wire logic LAT_EXPIRED_O,
	input wire logic [7:0] UPSTREAM_BUS_O,
	input wire logic [7:0] DOWNSTREAM_BUS_O,
	input wire logic PRI_SERR_OUT_OE_N_O
);
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	// Read completion cycle, where read data is valid
	wire logic rd_ok = PREADY_O && !PWRITE_I;

	// Fixed fields seen on every read
	status_fixed_a: assert property (rd_ok && PADDR_I == `BCR_OFS_STATUS |->
		{PRDATA_O[26:25], PRDATA_O[23:16]} == 10'h1b0) else $error("status constant bits wrong");
	class_code_a: assert property (rd_ok && PADDR_I == `BCR_OFS_CLASS |-> PRDATA_O[31:8] == 24'h060400)
		else $error("class code wrong");
	header_type_a: assert property (rd_ok && PADDR_I == `BCR_OFS_CACHE |-> PRDATA_O[23:16] == 8'h01)
		else $error("header type wrong");
	// Pin driven only for a cause seen the cycle before
	serr_cause_a: assert property (!PRI_SERR_OUT_OE_N_O |-> $past(EVENTS_I.serr_req || EVENTS_I.addr_perr))
		else $error("system error driven without cause");
	abort_flag_a: assert property (EVENTS_I.tgt_abort_sent ##[1:3] (PSEL_I && !PENABLE_I && !PWRITE_I &&
		PADDR_I == `BCR_OFS_STATUS) |=> PRDATA_O[27]) else $error("target abort flag missing");
	lat_cause_a: assert property (LAT_EXPIRED_O |-> $past(XFER_ACTIVE_I && !FRAME_START_I))
		else $error("latency expiry without transfer");
	line_end_cause_a: assert property (LINE_END_O |-> $past(XFER_ACTIVE_I)) else $error("line end idle");
	// Bus numbers move only on a committed write to their word
	bus_num_write_a: assert property ($changed({UPSTREAM_BUS_O, DOWNSTREAM_BUS_O}) |->
		$past(PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == `BCR_OFS_BUSNUM))
		else $error("bus number changed without write");

	cover property (rd_ok && PADDR_I == `BCR_OFS_STATUS && PRDATA_O[31]);
	cover property (!PRI_SERR_OUT_OE_N_O);
	cover property (LAT_EXPIRED_O);
endmodule // bcr_regs_chk

bind bcr_regs bcr_regs_chk chk_u (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
	.EVENTS_I(EVENTS_I), .FRAME_START_I(FRAME_START_I), .XFER_ACTIVE_I(XFER_ACTIVE_I), .LINE_END_O(LINE_END_O),
	.LAT_EXPIRED_O(LAT_EXPIRED_O), .UPSTREAM_BUS_O(UPSTREAM_BUS_O), .DOWNSTREAM_BUS_O(DOWNSTREAM_BUS_O),
	.PRI_SERR_OUT_OE_N_O(PRI_SERR_OUT_OE_N_O));

/* verif/tb.sv */
// Self-checking bench for the configuration register bank
`include "bcr_consts.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import bcr_pkg::*;
	localparam logic [7:0] REV = 8'h3c; // Arbitrary value
	localparam logic [31:0] ST0 = 32'h02b00000;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel, pen, pwr, pready, pslverr, line_end, lat_exp, serr, oe_n, e, oe_seen;
	logic frame = 1'b0;
	logic act = 1'b0;
	logic [7:0] paddr, line_dw, up, dn;
	logic [7:0] dword = 8'h00;
	logic [31:0] pwdata, prdata, q;
	bcr_evt_t evt = '0;
	int failures = 0;
	int samples_checked = 0;

	initial forever #50 clk = ~clk;

	bcr_regs #(.REVISION(REV)) dut_u (.SYS_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .EVENTS_I(evt), .FRAME_START_I(frame), .XFER_ACTIVE_I(act),
		.XFER_DWORD_I(dword), .LINE_END_O(line_end), .LINE_DWORDS_O(line_dw), .LAT_EXPIRED_O(lat_exp),
		.UPSTREAM_BUS_O(up), .DOWNSTREAM_BUS_O(dn), .PRI_SERR_OUT_O(serr), .PRI_SERR_OUT_OE_N_O(oe_n));
	bcr_cfg_master mst_u (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
		.penable(pen), .pwrite(pwr), .paddr(paddr), .pwdata(pwdata));

	// Compare, count and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		mst_u.xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		mst_u.xfer(1'b0, a, 32'h0, q, e);
		chk(q, exp);
	endtask
	// One-cycle event pulse; pin state sampled after it lands
	task automatic pulse(input int i);
		@(posedge clk);
		evt <= bcr_evt_t'(7'h01 << i);
		@(posedge clk);
		evt <= '0;
		@(negedge clk);
		oe_seen = oe_n;
	endtask
	// Status bit expected from each event line
	function automatic logic [31:0] flag_of(input int i);
		case (i)
			6: return 32'h01000000;
			5: return 32'h08000000;
			4: return 32'h10000000;
			3: return 32'h20000000;
			2, 1: return 32'h80000000;
			default: return 32'h40000000;
		endcase
	endfunction
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#2000000;
		failures++;
		final_report;
	end

	// Main sequence
	initial begin
		int i;
		logic [7:0] a, b;
		void'($urandom(66));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(`BCR_OFS_STATUS, ST0);
		wr(`BCR_OFS_CLASS, $urandom);
		rd(`BCR_OFS_CLASS, {24'h060400, REV});
		rd(`BCR_OFS_CACHE, 32'h00010000);
		rd(`BCR_OFS_BUSNUM, 32'h0);
		rd(8'h2c, 32'h0);
		chk(e, 1'b1);
		// Random timer and bus numbers, every legal line size, one line-end dword each
		for (i = 0; i < 7; i++) begin
			a = $urandom;
			b = (i == 5) ? 8'h00 : (i == 6) ? 8'h03 : 8'h01 << i;
			wr(`BCR_OFS_CACHE, {16'h0, a, b});
			rd(`BCR_OFS_CACHE, {16'h0001, a, b});
			wr(`BCR_OFS_BUSNUM, {16'h0, b ^ a, a});
			mst_u.xfer(1'b0, `BCR_OFS_BUSNUM, 32'h0, q, e);
			chk(q[15:0], {b ^ a, a});
			repeat (2) @(negedge clk);
			chk({dn, up, line_dw}, {b ^ a, a, (i == 6) ? 8'h00 : b});
			@(posedge clk);
			{act, dword} <= {1'b1, b - 8'h01};
			@(posedge clk);
			act <= 1'b0;
			@(negedge clk);
			chk(line_end, i < 5);
		end
		// Each event sets its flag; a zero write keeps it, a one clears it
		wr(`BCR_OFS_CTRL, 32'h140);
		for (i = 0; i < 7; i++) begin
			pulse(i);
			chk(oe_seen, !(i == 0 || i == 2));
			chk(serr, 1'b0);
			mst_u.xfer(1'b0, `BCR_OFS_STATUS, 32'h0, q, e);
			chk(q & flag_of(i), flag_of(i));
			wr(`BCR_OFS_STATUS, 32'h0);
			mst_u.xfer(1'b0, `BCR_OFS_STATUS, 32'h0, q, e);
			chk(q & flag_of(i), flag_of(i));
			wr(`BCR_OFS_STATUS, 32'hf9000000);
			rd(`BCR_OFS_STATUS, ST0);
		end
		// Enables off: no pin drive, no master parity flag
		wr(`BCR_OFS_CTRL, 32'h0);
		pulse(0);
		chk(oe_seen, 1'b1);
		pulse(6);
		mst_u.xfer(1'b0, `BCR_OFS_STATUS, 32'h0, q, e);
		chk({q[30], q[24]}, 2'b00);
		// Latency count of three runs out within a bounded span
		wr(`BCR_OFS_CACHE, 32'h00000300);
		@(posedge clk);
		{frame, act} <= 2'b11;
		@(posedge clk);
		frame <= 1'b0;
		@(negedge clk);
		chk(lat_exp, 1'b0);
		for (i = 0; i < 8 && lat_exp !== 1'b1; i++) @(negedge clk);
		chk(lat_exp, 1'b1);
		@(posedge clk);
		act <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(`BCR_OFS_BUSNUM, 32'h0);
		final_report;
	end
endmodule // tb
